// *** inc/cwm_defines.svh ***
`ifndef CWM_DEFINES_SVH
`define CWM_DEFINES_SVH
// ==========================================
// opcodes
`define CWM_OP_WMOV_RR 8'hc4
`define CWM_OP_WMOV_IR 8'hc5
`define CWM_OP_WMOV_IM 8'hc6
`define CWM_OP_MUL_R 8'h84
`define CWM_OP_MUL_IR 8'h85
`define CWM_OP_MUL_IM 8'h86
`define CWM_OP_NEXT 8'h0f
`define CWM_OP_NOP 8'hff
`define CWM_OP_OR_RR 8'h42
`define CWM_OP_OR_RI 8'h43
`define CWM_OP_OR_R 8'h44
`define CWM_OP_OR_IR 8'h45
`define CWM_OP_OR_IM 8'h46
`define CWM_OP_POP_R 8'h50
`define CWM_OP_POP_IR 8'h51
// ==========================================
// execution cycles and instruction lengths
`define CWM_CYC_WMOV 5'h08
`define CWM_CYC_MUL 5'h16
`define CWM_CYC_NEXT 5'h0a
`define CWM_CYC_NOP 5'h04
`define CWM_CYC_OR_SHORT 5'h04
`define CWM_CYC_OR_LONG 5'h06
`define CWM_CYC_POP 5'h08
`define CWM_CYC_BAD 5'h01
`define CWM_LEN_1 3'h1
`define CWM_LEN_2 3'h2
`define CWM_LEN_3 3'h3
`define CWM_LEN_4 3'h4
// ==========================================
// register file and software map (index = byte address / 4)
`define CWM_SP_HIGH 8'hd8
`define CWM_SP_LOW 8'hd9
`define CWM_WR_BASE 8'hc0
`define CWM_RF_SIZE 10'h100
`define CWM_IDX_PC 10'h100
`define CWM_IDX_TWP 10'h101
`define CWM_IDX_FLAGS 10'h102
`define CWM_IDX_STAT 10'h103
`define CWM_STAT_ILL 1
`define CWM_TWP_STEP 16'h0002
`define CWM_SP_STEP 16'h0001
`define CWM_MUL_MAX 16'h00ff
`define CWM_RESP_OKAY 2'h0
`define CWM_RESP_SLVERR 2'h2
`endif

// *** inc/cwm_pkg.sv ***
package cwm_pkg;
  typedef logic [7:0] cwm_byte_t;
  typedef enum logic {ST_IDLE, ST_RUN} cwm_state_e;
  typedef enum logic {ALU_OR, ALU_MUL} cwm_alu_e;
  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
    logic d;
    logic h;
    logic [1:0] rsvd;
  } cwm_flags_s;
  typedef struct packed {
    cwm_state_e st;
    logic [255:0][7:0] rf;
    logic [15:0] pc;
    logic [15:0] thread_word_pointer;
    cwm_flags_s fl;
    logic [7:0] opc;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [7:0] op3;
    logic [4:0] cnt;
    logic [2:0] len;
    logic done;
    logic illegal;
  } cwm_core_s;
  typedef struct packed {
    logic aw_ok;
    logic [9:0] aw_idx;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_ok;
    logic [9:0] ar_idx;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
  } cwm_axil_s;
endpackage

// *** inc/cwm_reg_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cwm_reg_if;
  logic wr_req;
  logic rd_req;
  logic [9:0] idx;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic ack;
  logic err;
  logic [31:0] rdata;
  modport bus (output wr_req, rd_req, idx, wdata, wstrb, input ack, err, rdata);
  modport core (input wr_req, rd_req, idx, wdata, wstrb, output ack, err, rdata);
endinterface
`default_nettype wire

// *** logic/cwm_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cwm_defines.svh"
module cwm_alu (
  input wire cwm_pkg::cwm_alu_e i_op,
  input wire cwm_pkg::cwm_byte_t i_a,
  input wire cwm_pkg::cwm_byte_t i_b,
  output logic [15:0] o_res,
  output logic o_c,
  output logic o_z,
  output logic o_s
);
  import cwm_pkg::*;
  // ==========================================
  // unsigned product or bitwise or
  always_comb
  begin
    if (i_op == ALU_MUL)
    begin
      o_res = {8'h00, i_a} * {8'h00, i_b};
      o_c = (o_res > `CWM_MUL_MAX);
      o_z = (o_res == 16'h0000);
      o_s = o_res[15];
    end
    else
    begin
      o_res = {8'h00, i_a | i_b};
      o_c = 1'b0;
      o_z = (o_res[7:0] == 8'h00);
      o_s = o_res[7];
    end
  end
endmodule // cwm_alu
`default_nettype wire

// *** logic/cwm_axil_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cwm_defines.svh"
module cwm_axil_slave (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [11:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [11:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  cwm_reg_if.bus rif
);
  import cwm_pkg::*;
  cwm_axil_s s_reg;
  cwm_axil_s s_next;
  // ==========================================
  // channel handshakes; one write and one read in flight
  assign o_awready = i_ce && !s_reg.aw_ok && !s_reg.b_valid;
  assign o_wready = i_ce && !s_reg.w_ok && !s_reg.b_valid;
  assign o_arready = i_ce && !s_reg.ar_ok && !s_reg.r_valid;
  assign o_bvalid = s_reg.b_valid;
  assign o_bresp = s_reg.b_resp;
  assign o_rvalid = s_reg.r_valid;
  assign o_rdata = s_reg.r_data;
  assign o_rresp = s_reg.r_resp;
  // reads go first: they never wait on the core
  assign rif.rd_req = s_reg.ar_ok;
  assign rif.wr_req = s_reg.aw_ok && s_reg.w_ok && !s_reg.ar_ok;
  assign rif.idx = s_reg.ar_ok ? s_reg.ar_idx : s_reg.aw_idx;
  assign rif.wdata = s_reg.wdata;
  assign rif.wstrb = s_reg.wstrb;
  always_comb
  begin
    s_next = s_reg;
    if (i_awvalid && o_awready)
    begin
      s_next.aw_ok = 1'b1;
      s_next.aw_idx = i_awaddr[11:2];
    end
    if (i_wvalid && o_wready)
    begin
      s_next.w_ok = 1'b1;
      s_next.wdata = i_wdata;
      s_next.wstrb = i_wstrb;
    end
    if (i_arvalid && o_arready)
    begin
      s_next.ar_ok = 1'b1;
      s_next.ar_idx = i_araddr[11:2];
    end
    if (s_reg.b_valid && i_bready)
      s_next.b_valid = 1'b0;
    if (s_reg.r_valid && i_rready)
      s_next.r_valid = 1'b0;
    if (rif.rd_req && rif.ack)
    begin
      s_next.ar_ok = 1'b0;
      s_next.r_valid = 1'b1;
      s_next.r_data = rif.rdata;
      s_next.r_resp = rif.err ? `CWM_RESP_SLVERR : `CWM_RESP_OKAY;
    end
    if (rif.wr_req && rif.ack)
    begin
      s_next.aw_ok = 1'b0;
      s_next.w_ok = 1'b0;
      s_next.b_valid = 1'b1;
      s_next.b_resp = rif.err ? `CWM_RESP_SLVERR : `CWM_RESP_OKAY;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      s_reg <= '0;
    else if (i_ce)
      s_reg <= s_next;
  end
endmodule // cwm_axil_slave
`default_nettype wire

// *** logic/cwm_core.sv ***
// Functional notes
// - word move copies source word, flags untouched
// - even source byte lands at even destination
// - unsigned eight by eight multiply into pair
// - even register high byte, odd low byte
// - multiply sets C Z S, clears V
// - multiply opcodes 84 to 86, 22 cycles
// - threaded next loads PC, pointer plus two
// - no-operation changes only PC (plus one) for four cycles
// - or stores dst OR src into dst
// - or sets Z S, clears V, keeps rest
// - pop reads stack top, then pointer plus one
// - stack pointer is two consecutive byte registers
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "cwm_defines.svh"
module cwm_core #(
  parameter logic [7:0] WR_BASE = `CWM_WR_BASE
) (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire logic I_CE,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [11:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [11:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_INSTR_VALID,
  output logic O_INSTR_READY,
  input wire cwm_pkg::cwm_byte_t I_OPCODE,
  input wire cwm_pkg::cwm_byte_t I_OP1,
  input wire cwm_pkg::cwm_byte_t I_OP2,
  input wire cwm_pkg::cwm_byte_t I_OP3,
  output logic O_INSTR_DONE,
  output logic [2:0] O_INSTR_LEN,
  output logic [15:0] O_PC,
  output logic [15:0] O_PM_ADDR,
  input wire logic [15:0] I_PM_DATA,
  output logic O_ILLEGAL
);
  import cwm_pkg::*;
  cwm_core_s s_reg;
  cwm_core_s s_next;
  cwm_reg_if rif();
  cwm_alu_e alu_op;
  cwm_byte_t dst_a;
  cwm_byte_t opnd_b;
  logic [15:0] word;
  logic [15:0] alu_res;
  logic alu_c;
  logic alu_z;
  logic alu_s;
  logic [15:0] sp;
  logic [7:0] info;
  logic accept;
  logic commit;

  // ==========================================
  // helpers
  function automatic cwm_byte_t even_of(input cwm_byte_t a);
    return {a[7:1], 1'b0};
  endfunction
  function automatic cwm_byte_t odd_of(input cwm_byte_t a);
    return {a[7:1], 1'b1};
  endfunction
  function automatic cwm_byte_t wreg(input logic [3:0] r);
    return {WR_BASE[7:4], r};
  endfunction
  function automatic logic [15:0] rd_word(input cwm_byte_t a);
    return {s_reg.rf[even_of(a)], s_reg.rf[odd_of(a)]};
  endfunction
  // {length, cycles}; unknown codes take one cycle and flag illegal
  function automatic logic [7:0] op_info(input cwm_byte_t op);
    logic [7:0] r;
    r = {`CWM_LEN_1, `CWM_CYC_BAD};
    unique case (op)
      `CWM_OP_WMOV_RR, `CWM_OP_WMOV_IR: r = {`CWM_LEN_3, `CWM_CYC_WMOV};
      `CWM_OP_WMOV_IM: r = {`CWM_LEN_4, `CWM_CYC_WMOV};
      `CWM_OP_MUL_R, `CWM_OP_MUL_IR, `CWM_OP_MUL_IM: r = {`CWM_LEN_3, `CWM_CYC_MUL};
      `CWM_OP_NEXT: r = {`CWM_LEN_1, `CWM_CYC_NEXT};
      `CWM_OP_NOP: r = {`CWM_LEN_1, `CWM_CYC_NOP};
      `CWM_OP_OR_RR: r = {`CWM_LEN_2, `CWM_CYC_OR_SHORT};
      `CWM_OP_OR_RI: r = {`CWM_LEN_2, `CWM_CYC_OR_LONG};
      `CWM_OP_OR_R, `CWM_OP_OR_IR, `CWM_OP_OR_IM: r = {`CWM_LEN_3, `CWM_CYC_OR_LONG};
      `CWM_OP_POP_R, `CWM_OP_POP_IR: r = {`CWM_LEN_2, `CWM_CYC_POP};
      default: r = {`CWM_LEN_1, `CWM_CYC_BAD};
    endcase
    return r;
  endfunction

  // ==========================================
  // bus slave and arithmetic
  cwm_axil_slave u_bus (
    .i_clk(I_CLK),
    .i_rst_n(I_RST_N),
    .i_ce(I_CE),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_awaddr(I_AWADDR),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .o_bvalid(O_BVALID),
    .i_bready(I_BREADY),
    .o_bresp(O_BRESP),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .i_araddr(I_ARADDR),
    .o_rvalid(O_RVALID),
    .i_rready(I_RREADY),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .rif(rif.bus)
  );
  cwm_alu u_alu (
    .i_op(alu_op),
    .i_a(s_reg.rf[dst_a]),
    .i_b(opnd_b),
    .o_res(alu_res),
    .o_c(alu_c),
    .o_z(alu_z),
    .o_s(alu_s)
  );

  // ==========================================
  // operand decode from the latched instruction
  assign sp = {s_reg.rf[`CWM_SP_HIGH], s_reg.rf[`CWM_SP_LOW]};
  always_comb
  begin
    dst_a = s_reg.op1;
    opnd_b = s_reg.op2;
    word = {s_reg.op2, s_reg.op3};
    alu_op = ALU_OR;
    unique case (s_reg.opc)
      `CWM_OP_WMOV_RR:
      begin
        dst_a = even_of(s_reg.op2);
        word = rd_word(s_reg.op1);
      end
      `CWM_OP_WMOV_IR:
      begin
        dst_a = even_of(s_reg.op2);
        word = rd_word(s_reg.rf[s_reg.op1]);
      end
      `CWM_OP_WMOV_IM: dst_a = even_of(s_reg.op1);
      `CWM_OP_MUL_R, `CWM_OP_MUL_IR, `CWM_OP_MUL_IM:
      begin
        alu_op = ALU_MUL;
        dst_a = even_of(s_reg.op2);
        if (s_reg.opc == `CWM_OP_MUL_R)
          opnd_b = s_reg.rf[s_reg.op1];
        else if (s_reg.opc == `CWM_OP_MUL_IR)
          opnd_b = s_reg.rf[s_reg.rf[s_reg.op1]];
        else
          opnd_b = s_reg.op1;
      end
      `CWM_OP_OR_RR, `CWM_OP_OR_RI:
      begin
        dst_a = wreg(s_reg.op1[7:4]);
        if (s_reg.opc == `CWM_OP_OR_RR)
          opnd_b = s_reg.rf[wreg(s_reg.op1[3:0])];
        else
          opnd_b = s_reg.rf[s_reg.rf[wreg(s_reg.op1[3:0])]];
      end
      `CWM_OP_OR_R: 
      begin
        dst_a = s_reg.op2;
        opnd_b = s_reg.rf[s_reg.op1];
      end
      `CWM_OP_OR_IR:
      begin
        dst_a = s_reg.op2;
        opnd_b = s_reg.rf[s_reg.rf[s_reg.op1]];
      end
      `CWM_OP_POP_IR: dst_a = s_reg.rf[s_reg.op1];
      default: dst_a = s_reg.op1;
    endcase
  end

  // ==========================================
  // register access from the bus; writes wait while an instruction runs
  assign rif.ack = rif.rd_req || (rif.wr_req && s_reg.st == ST_IDLE);
  assign rif.err = (rif.idx > `CWM_IDX_STAT);
  always_comb
  begin
    if (rif.idx < `CWM_RF_SIZE)
      rif.rdata = {24'h000000, s_reg.rf[rif.idx[7:0]]};
    else if (rif.idx == `CWM_IDX_PC)
      rif.rdata = {16'h0000, s_reg.pc};
    else if (rif.idx == `CWM_IDX_TWP)
      rif.rdata = {16'h0000, s_reg.thread_word_pointer};
    else if (rif.idx == `CWM_IDX_FLAGS)
      rif.rdata = {24'h000000, s_reg.fl};
    else if (rif.idx == `CWM_IDX_STAT)
      rif.rdata = {30'h00000000, s_reg.illegal, s_reg.st == ST_RUN};
    else
      rif.rdata = 32'h00000000;
  end

  // ==========================================
  // sequencing and commit
  assign info = op_info(I_OPCODE);
  assign accept = I_CE && I_INSTR_VALID && s_reg.st == ST_IDLE;
  assign commit = s_reg.st == ST_RUN && s_reg.cnt == 5'h00;
  assign O_INSTR_READY = I_CE && s_reg.st == ST_IDLE;
  assign O_INSTR_DONE = s_reg.done;
  assign O_INSTR_LEN = s_reg.len;
  assign O_PC = s_reg.pc;
  assign O_PM_ADDR = s_reg.thread_word_pointer;
  assign O_ILLEGAL = s_reg.illegal;
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    if (rif.wr_req && rif.ack && !rif.err)
    begin
      if (rif.idx < `CWM_RF_SIZE && rif.wstrb[0])
        s_next.rf[rif.idx[7:0]] = rif.wdata[7:0];
      if (rif.idx == `CWM_IDX_PC && rif.wstrb[0])
        s_next.pc[7:0] = rif.wdata[7:0];
      if (rif.idx == `CWM_IDX_PC && rif.wstrb[1])
        s_next.pc[15:8] = rif.wdata[15:8];
      if (rif.idx == `CWM_IDX_TWP && rif.wstrb[0])
        s_next.thread_word_pointer[7:0] = rif.wdata[7:0];
      if (rif.idx == `CWM_IDX_TWP && rif.wstrb[1])
        s_next.thread_word_pointer[15:8] = rif.wdata[15:8];
      if (rif.idx == `CWM_IDX_FLAGS && rif.wstrb[0])
        s_next.fl = {rif.wdata[7:2], 2'b00};
      if (rif.idx == `CWM_IDX_STAT && rif.wstrb[0] && rif.wdata[`CWM_STAT_ILL])
        s_next.illegal = 1'b0;
    end
    if (accept)
    begin
      s_next.st = ST_RUN;
      s_next.opc = I_OPCODE;
      s_next.op1 = I_OP1;
      s_next.op2 = I_OP2;
      s_next.op3 = I_OP3;
      s_next.len = info[7:5];
      s_next.cnt = info[4:0] - 5'h01;
    end
    else if (commit)
    begin
      s_next.st = ST_IDLE;
      s_next.done = 1'b1;
      s_next.pc = s_reg.pc + {13'h0000, s_reg.len};
      unique case (s_reg.opc)
        `CWM_OP_WMOV_RR, `CWM_OP_WMOV_IR, `CWM_OP_WMOV_IM:
        begin
          s_next.rf[dst_a] = word[15:8];
          s_next.rf[odd_of(dst_a)] = word[7:0];
        end
        `CWM_OP_MUL_R, `CWM_OP_MUL_IR, `CWM_OP_MUL_IM:
        begin
          s_next.rf[dst_a] = alu_res[15:8];
          s_next.rf[odd_of(dst_a)] = alu_res[7:0];
          s_next.fl.c = alu_c;
          s_next.fl.z = alu_z;
          s_next.fl.s = alu_s;
          s_next.fl.v = 1'b0;
        end
        `CWM_OP_OR_RR, `CWM_OP_OR_RI, `CWM_OP_OR_R, `CWM_OP_OR_IR, `CWM_OP_OR_IM:
        begin
          s_next.rf[dst_a] = alu_res[7:0];
          s_next.fl.z = alu_z;
          s_next.fl.s = alu_s;
          s_next.fl.v = 1'b0;
        end
        `CWM_OP_NEXT:
        begin
          s_next.pc = I_PM_DATA;
          s_next.thread_word_pointer = s_reg.thread_word_pointer + `CWM_TWP_STEP;
        end
        `CWM_OP_POP_R, `CWM_OP_POP_IR:
        begin
          // only the low byte reaches the 256-byte register file
          s_next.rf[dst_a] = s_reg.rf[sp[7:0]];
          {s_next.rf[`CWM_SP_HIGH], s_next.rf[`CWM_SP_LOW]} = sp + `CWM_SP_STEP;
        end
        `CWM_OP_NOP: s_next.done = 1'b1;
        default: s_next.illegal = 1'b1;
      endcase
    end
    else if (s_reg.st == ST_RUN)
      s_next.cnt = s_reg.cnt - 5'h01;
  end
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      s_reg <= '0;
    else if (I_CE)
      s_reg <= s_next;
  end

  // ==========================================
  // checks
  logic [4:0] run_cnt;
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      run_cnt <= 5'h00;
    else if (I_CE && accept)
      run_cnt <= 5'h00;
    else if (I_CE && s_reg.st == ST_RUN)
      run_cnt <= run_cnt + 5'h01;
  end
  mul_time_a:
  assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (commit && s_reg.opc inside {`CWM_OP_MUL_R, `CWM_OP_MUL_IR, `CWM_OP_MUL_IM})
    |-> run_cnt == `CWM_CYC_MUL - 5'h01)
    else $error("multiply did not take its cycle count");
  short_time_a:
  assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    commit |-> (s_reg.opc != `CWM_OP_NOP || run_cnt == `CWM_CYC_NOP - 5'h01)
      && (s_reg.opc != `CWM_OP_NEXT || run_cnt == `CWM_CYC_NEXT - 5'h01)
      && (s_reg.opc != `CWM_OP_WMOV_RR || run_cnt == `CWM_CYC_WMOV - 5'h01)
      && (s_reg.opc != `CWM_OP_POP_R || run_cnt == `CWM_CYC_POP - 5'h01))
    else $error("instruction cycle count wrong");
  word_move_a:
  assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && commit && s_reg.opc == `CWM_OP_WMOV_RR)
    |=> s_reg.rf[{$past(s_reg.op2[7:1]), 1'b0}] == $past(s_reg.rf[{s_reg.op1[7:1], 1'b0}])
      && s_reg.rf[{$past(s_reg.op2[7:1]), 1'b1}] == $past(s_reg.rf[{s_reg.op1[7:1], 1'b1}])
      && s_reg.fl == $past(s_reg.fl))
    else $error("word move result wrong");
  mul_result_a:
  assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && commit && s_reg.opc == `CWM_OP_MUL_IM)
    |=> {s_reg.rf[{$past(s_reg.op2[7:1]), 1'b0}], s_reg.rf[{$past(s_reg.op2[7:1]), 1'b1}]}
      == $past(s_reg.rf[{s_reg.op2[7:1], 1'b0}]) * $past(s_reg.op1))
    else $error("product or byte order wrong");
  mul_flags_a:
  assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && commit && s_reg.opc == `CWM_OP_MUL_IM)
    |=> !s_reg.fl.v && s_reg.fl.d == $past(s_reg.fl.d) && s_reg.fl.h == $past(s_reg.fl.h)
      && s_reg.fl.c == (s_reg.rf[{$past(s_reg.op2[7:1]), 1'b0}] != 8'h00))
    else $error("multiply flags wrong");
  next_step_a:
  assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && commit && s_reg.opc == `CWM_OP_NEXT)
    |=> s_reg.pc == $past(I_PM_DATA)
      && s_reg.thread_word_pointer == $past(s_reg.thread_word_pointer) + `CWM_TWP_STEP
      && s_reg.fl == $past(s_reg.fl))
    else $error("threaded next wrong");
  nop_quiet_a:
  assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && commit && s_reg.opc == `CWM_OP_NOP)
    |=> s_reg.rf == $past(s_reg.rf) && s_reg.fl == $past(s_reg.fl) && O_INSTR_DONE)
    else $error("no-operation changed state");
  or_indirect_a:
  assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && commit && s_reg.opc == `CWM_OP_OR_IR)
    |=> s_reg.rf[$past(s_reg.op2)] == $past(s_reg.rf[s_reg.op2] | s_reg.rf[s_reg.rf[s_reg.op1]])
      && !s_reg.fl.v && s_reg.fl.c == $past(s_reg.fl.c)
      && s_reg.fl.z == (s_reg.rf[$past(s_reg.op2)] == 8'h00))
    else $error("or result or flags wrong");
  pop_stack_a:
  assert property (@(posedge I_CLK) disable iff (!I_RST_N)
    (I_CE && commit && s_reg.opc == `CWM_OP_POP_R && s_reg.op1[7:1] != 7'h6c)
    |=> {s_reg.rf[`CWM_SP_HIGH], s_reg.rf[`CWM_SP_LOW]} == $past(sp) + `CWM_SP_STEP
      && s_reg.rf[$past(s_reg.op1)] == $past(s_reg.rf[sp[7:0]]))
    else $error("pop wrong");
endmodule // cwm_core
`default_nettype wire

// *** verif/cpu_word_mul_or_pop_ops_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "cwm_defines.svh"
module cpu_word_mul_or_pop_ops_bench;
  import cwm_pkg::*;
  logic clk, rst_n, ce, awv, wv, br, arv, rr, iv, awr, wr, bv, arr, rv, ir, dn, ill;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] bresp, rresp;
  cwm_byte_t opc, b1, b2, b3;
  logic [2:0] ilen;
  logic [15:0] pc, pma, pmd;
  int failures, checks_done;

  cwm_core dut (.I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr), .I_WDATA(wd), .I_WSTRB(4'hf),
    .O_BVALID(bv), .I_BREADY(br), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr),
    .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rr), .O_RDATA(rdat), .O_RRESP(rresp),
    .I_INSTR_VALID(iv), .O_INSTR_READY(ir), .I_OPCODE(opc), .I_OP1(b1), .I_OP2(b2),
    .I_OP3(b3), .O_INSTR_DONE(dn), .O_INSTR_LEN(ilen), .O_PC(pc), .O_PM_ADDR(pma),
    .I_PM_DATA(pmd), .O_ILLEGAL(ill));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================
  // checking and closing
  task end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task tmo(input int n);
    if (n >= 60)
    begin
      failures++;
      end_of_test();
    end
  endtask

  // ==========================================
  // bus and instruction drivers
  // handshakes judged at the falling edge, where the next rising edge samples the same values
  task axw(input logic [9:0] i, input logic [31:0] d, output logic [1:0] rs);
    int n;
    logic ta, tw, tb;
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= {i, 2'h0};
    wd <= d;
    br <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(negedge clk);
      ta = awv & awr;
      tw = wv & wr;
      tb = bv;
      rs = bresp;
      @(posedge clk);
      if (ta)
        awv <= 1'b0;
      if (tw)
        wv <= 1'b0;
      if (tb)
        break;
    end
    br <= 1'b0;
    @(posedge clk);
    tmo(n);
  endtask

  task axr(input logic [9:0] i, output logic [31:0] d, output logic [1:0] rs);
    int n;
    logic ta, tb;
    arv <= 1'b1;
    ara <= {i, 2'h0};
    rr <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(negedge clk);
      ta = arv & arr;
      tb = rv;
      d = rdat;
      rs = rresp;
      @(posedge clk);
      if (ta)
        arv <= 1'b0;
      if (tb)
        break;
    end
    rr <= 1'b0;
    @(posedge clk);
    tmo(n);
  endtask

  task w8(input logic [9:0] i, input logic [31:0] d);
    logic [1:0] r;
    axw(i, d, r);
  endtask

  task ck(input logic [9:0] i, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(i, d, r);
    chk($sformatf("reg %h", i), d, e);
  endtask

  // k counts edges from the take edge to the one that raises done
  task run(input cwm_byte_t o, input cwm_byte_t x, input cwm_byte_t y, input cwm_byte_t z,
    output int k);
    int n;
    logic t;
    iv <= 1'b1;
    opc <= o;
    b1 <= x;
    b2 <= y;
    b3 <= z;
    for (n = 0; n < 60; n++)
    begin
      @(negedge clk);
      t = ir;
      @(posedge clk);
      if (t)
        break;
    end
    iv <= 1'b0;
    tmo(n);
    for (k = 0; k < 60; k++)
    begin
      @(negedge clk);
      if (dn === 1'b1)
        break;
      @(posedge clk);
    end
    @(posedge clk);
    tmo(k);
  endtask

  // ==========================================
  // scenarios
  task t_ldw;
    int k;
    w8(10'h102, 32'ha4);
    w8(10'h002, 32'h03);
    w8(10'h003, 32'h0f);
    w8(10'h010, 32'h02);
    run(8'hc4, 8'h02, 8'h00, 8'h00, k);
    chk("cycles", k, 32'h08);
    chk("length", {29'h0, ilen}, 32'h03);
    ck(10'h000, 32'h03);
    ck(10'h001, 32'h0f);
    ck(10'h002, 32'h03);
    run(8'hc5, 8'h10, 8'h04, 8'h00, k);
    chk("cycles", k, 32'h08);
    ck(10'h004, 32'h03);
    ck(10'h005, 32'h0f);
    run(8'hc6, 8'h06, 8'h12, 8'h34, k);
    chk("length", {29'h0, ilen}, 32'h04);
    ck(10'h006, 32'h12);
    ck(10'h007, 32'h34);
    ck(10'h102, 32'ha4);
  endtask

  task t_mul;
    int k;
    w8(10'h000, 32'h20);
    w8(10'h002, 32'h09);
    w8(10'h102, 32'h1c);
    run(8'h84, 8'h02, 8'h00, 8'h00, k);
    chk("cycles", k, 32'h16);
    chk("length", {29'h0, ilen}, 32'h03);
    ck(10'h000, 32'h01);
    ck(10'h001, 32'h20);
    ck(10'h002, 32'h09);
    ck(10'h102, 32'h8c);
    chk("illegal", {31'h0, ill}, 32'h0);
    run(8'h86, 8'h00, 8'h00, 8'h00, k);
    ck(10'h000, 32'h00);
    ck(10'h102, 32'h4c);
    w8(10'h000, 32'hff);
    w8(10'h030, 32'h31);
    w8(10'h031, 32'hff);
    run(8'h85, 8'h30, 8'h00, 8'h00, k);
    chk("cycles", k, 32'h16);
    ck(10'h000, 32'hfe);
    ck(10'h001, 32'h01);
    ck(10'h102, 32'hac);
  endtask

  task t_next_nop;
    int k;
    logic [15:0] p;
    w8(10'h101, 32'h0100);
    w8(10'h102, 32'h00);
    pmd <= 16'h1234;
    chk("pm address", {16'h0, pma}, 32'h0100);
    run(8'h0f, 8'h00, 8'h00, 8'h00, k);
    chk("cycles", k, 32'h0a);
    chk("length", {29'h0, ilen}, 32'h01);
    chk("pc", {16'h0, pc}, 32'h1234);
    ck(10'h101, 32'h0102);
    ck(10'h102, 32'h00);
    p = pc;
    run(8'hff, 8'h00, 8'h00, 8'h00, k);
    chk("cycles", k, 32'h04);
    chk("pc", {16'h0, pc}, {16'h0, p + 16'h0001});
    ck(10'h000, 32'hfe);
    ck(10'h102, 32'h00);
    // an offered instruction must not be taken while frozen
    ce <= 1'b0;
    iv <= 1'b1;
    repeat (6) @(posedge clk);
    chk("frozen pc", {16'h0, pc}, {16'h0, p + 16'h0001});
    chk("frozen ready", {31'h0, ir}, 32'h0);
    ce <= 1'b1;
    iv <= 1'b0;
  endtask

  task t_or;
    int k;
    w8(10'h102, 32'h9c);
    w8(10'h0c0, 32'h15);
    w8(10'h0c1, 32'h2a);
    run(8'h42, 8'h01, 8'h00, 8'h00, k);
    chk("cycles", k, 32'h04);
    chk("length", {29'h0, ilen}, 32'h02);
    ck(10'h0c0, 32'h3f);
    ck(10'h0c1, 32'h2a);
    ck(10'h102, 32'h8c);
    w8(10'h0c2, 32'h50);
    w8(10'h050, 32'h40);
    run(8'h43, 8'h02, 8'h00, 8'h00, k);
    chk("cycles", k, 32'h06);
    ck(10'h0c0, 32'h7f);
    w8(10'h041, 32'h00);
    w8(10'h042, 32'h00);
    run(8'h44, 8'h41, 8'h42, 8'h00, k);
    ck(10'h102, 32'hcc);
    w8(10'h051, 32'h52);
    w8(10'h052, 32'h80);
    run(8'h45, 8'h51, 8'h42, 8'h00, k);
    ck(10'h042, 32'h80);
    ck(10'h102, 32'hac);
    run(8'h46, 8'h42, 8'h01, 8'h00, k);
    chk("length", {29'h0, ilen}, 32'h03);
    ck(10'h042, 32'h81);
  endtask

  task t_pop;
    int k;
    w8(10'h0d8, 32'h00);
    w8(10'h0d9, 32'hfb);
    w8(10'h0fb, 32'h55);
    w8(10'h0fc, 32'h66);
    w8(10'h102, 32'ha4);
    run(8'h50, 8'h00, 8'h00, 8'h00, k);
    chk("cycles", k, 32'h08);
    chk("length", {29'h0, ilen}, 32'h02);
    ck(10'h000, 32'h55);
    ck(10'h0d9, 32'hfc);
    ck(10'h0d8, 32'h00);
    w8(10'h000, 32'h01);
    run(8'h51, 8'h00, 8'h00, 8'h00, k);
    ck(10'h001, 32'h66);
    ck(10'h0d9, 32'hfd);
    ck(10'h102, 32'ha4);
  endtask

  task t_bus;
    logic [31:0] d;
    logic [1:0] r;
    axr(10'h104, d, r);
    chk("read resp", {30'h0, r}, 32'h02);
    chk("read data", d, 32'h00);
    axw(10'h104, 32'h5a, r);
    chk("write resp", {30'h0, r}, 32'h02);
  endtask

  initial
  begin
    {rst_n, awv, wv, br, arv, rr, iv} = '0;
    {awa, ara, wd, opc, b1, b2, b3, pmd} = '0;
    ce = 1'b1;
    failures = 0;
    checks_done = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_ldw();
    t_mul();
    t_next_nop();
    t_or();
    t_pop();
    t_bus();
    end_of_test();
  end
endmodule // cpu_word_mul_or_pop_ops_bench
`default_nettype wire
